// ===== verilog/lbd_pkg.sv
// shared constants for the local bus decode and acknowledge block
package lbd_pkg;
  localparam int ADDR_W = 24;
  localparam logic [23:0] RAM_BASE_RST = 24'h000000;
  localparam logic [23:0] RAM_SIZE = 24'h020000;
  localparam logic [23:0] PROM_BASE_RST = 24'hF80000;
  localparam logic [23:0] PROM_LAST_OFS = 24'h02FFFF;
  localparam logic [23:0] IO_BASE = 24'hFF0000;
  localparam logic [23:0] IO_LAST = 24'hFFFFFF;
  localparam logic [23:0] BOOT_LAST = 24'h000007;
  localparam int BOOT_ACCESSES = 4;
  localparam int ACK_TAPS = 8;
  localparam int CLK_MHZ = 100;
  localparam int BUS_TOUT_US = 1000;
  localparam int BUS_TOUT_CYC = BUS_TOUT_US * CLK_MHZ;
  localparam int LOC_TOUT_US = 100;
  localparam int LOC_TOUT_CYC = LOC_TOUT_US * CLK_MHZ;
  localparam int SYSCLK_MHZ = 16;
  localparam int SYSCLK_ACC_W = 8;
  localparam logic [7:0] SYSCLK_STEP = 8'h29;
  localparam logic [3:0] WAIT_RAM_RST = 4'h0;
  localparam logic [3:0] WAIT_PROM_RST = 4'h2;
  typedef enum logic [1:0] {
    LBD_SEL_VME,
    LBD_SEL_RAM,
    LBD_SEL_PROM,
    LBD_SEL_IO
  } lbd_sel_t;
endpackage

// ===== verilog/lbd_ack_if.sv
// carrier between decoder and acknowledge shift register
`timescale 1ns/100ps
interface lbd_ack_if;
  logic run;
  logic tick;
  logic [3:0] wait_cyc;
  logic ack;
  modport ctl (output run, output tick, output wait_cyc, input ack);
  modport gen (input run, input tick, input wait_cyc, output ack);
endinterface

// ===== verilog/lbd_ack_gen.sv
// memory acknowledge shift register
`timescale 1ns/100ps
module lbd_ack_gen #(
  parameter int TAPS = lbd_pkg::ACK_TAPS
) (
  input wire logic clk,
  input wire logic rst,
  lbd_ack_if.gen a
);
  logic [TAPS:0] sh_r;
  logic [TAPS:0] sh_nxt;
  logic [3:0] tap;

  initial begin
    if (TAPS < 1 || TAPS > 15) begin
      $error("ack taps out of range");
    end
  end

  // tap beyond the chain is clamped to the last stage
  assign tap = (a.wait_cyc > 4'(TAPS)) ? 4'(TAPS) : a.wait_cyc;
  // shifts only on processor clock ticks; cleared when strobe ends
  assign sh_nxt = !a.run ? '0 :
                  a.tick ? {sh_r[TAPS-1:0], 1'b1} : sh_r;
  // stage 0 is the first tick of the access, so tap 0 has no wait
  assign a.ack = a.run && sh_r[tap];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sh_r <= '0;
    end else begin
      sh_r <= sh_nxt;
    end
  end
endmodule

// ===== verilog/lbd_top.sv
// address decode, acknowledge, watchdogs, interrupts and status glue
// How it works
// - addresses outside ram, prom and io windows go to a vme cycle
// - default 128k ram window starts at address zero
// - io window is ff0000 through ffffff
// - default prom window is f80000 through faffff
// - vme cycles take acknowledge from the responding bus slave
// - ram and prom acknowledge after separately set delays
// - cpu clock is oscillator over two, also times acknowledge delays
// - local watchdog timeout drives cpu bus error when enabled
// - local timeout alerts cpu only; bus timeout drives vme berr
// - as system controller, flag vme berr on cycles over 1 ms
// - bus error on unanswered off-board or on-board io accesses
// - on-board memory always acknowledged, never bus error
// - 16 mhz sysclk source with switchable bus connection
// - priority encoder drives three ipl lines from selected sources
// - each level selects vectored or autovectored acknowledge
// - on-board sources share one level with selectable priority
// - board fail bit lights indicator and drives sysfail
// - sysfail and acfail go to status and handshake inputs
// - first four word accesses after reset go to prom bytes 0-7
// - boot redirect ignores prom base; normal decode afterwards
// - acknowledge shift register gives zero to eight waits
// - iack level on a1-a3 decoded one of eight for vector mode
`timescale 1ns/100ps
module lbd_top #(
  parameter int BUS_TOUT = lbd_pkg::BUS_TOUT_CYC,
  parameter int LOC_TOUT = lbd_pkg::LOC_TOUT_CYC
) (
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic [23:1] CPU_ADDR,
  input wire logic CPU_AS_N,
  input wire logic CPU_IACK,
  input wire logic [23:0] RAM_BASE,
  input wire logic [23:0] PROM_BASE,
  input wire logic [3:0] RAM_WAIT,
  input wire logic [3:0] PROM_WAIT,
  input wire logic IO_DTACK_N,
  input wire logic VME_DTACK_N,
  input wire logic VME_BERR_IN_N,
  input wire logic VME_AS_N,
  input wire logic BERR_CPU_EN,
  input wire logic SYS_CTRL_EN,
  input wire logic SYSCLK_DRIVE_EN,
  input wire logic [7:1] VME_IRQ_N,
  input wire logic [7:1] IRQ_ROUTE_EN,
  input wire logic [2:0] ONBOARD_LEVEL,
  input wire logic [2:0] ONB_IRQ,
  input wire logic [5:0] ONB_PRIO,
  input wire logic [7:1] AUTOVEC_SEL,
  input wire logic BOARD_FAIL_FLAG,
  input wire logic VME_SYSFAIL_IN_N,
  input wire logic VME_ACFAIL_IN_N,
  output logic CPU_CLK,
  output logic CPU_DTACK_N,
  output logic CPU_BERR_N,
  output logic VME_CYCLE,
  output logic RAM_SEL,
  output logic PROM_SEL,
  output logic IO_SEL,
  output logic BOOT_ACTIVE,
  output logic VME_BERR_OUT,
  output logic VME_BERR_OE,
  output logic VME_SYSCLK_OUT,
  output logic VME_SYSCLK_OE,
  output logic CPU_IRQ_LEVEL_BIT2,
  output logic CPU_IRQ_LEVEL_BIT1,
  output logic CPU_IRQ_LEVEL_BIT0,
  output logic ONBOARD_COMPOSITE_IRQ,
  output logic [2:0] ONB_IACK,
  output logic IACK_AUTOVEC,
  output logic IACK_VECTORED,
  output logic BOARD_FAIL_LED,
  output logic VME_SYSFAIL_OUT,
  output logic VME_SYSFAIL_OE,
  output logic SYSFAIL_STATUS_IN,
  output logic ACFAIL_STATUS_IN,
  output logic SYSFAIL_HANDSHAKE_IN,
  output logic ACFAIL_HANDSHAKE_IN
);
  localparam int BW = $clog2(BUS_TOUT + 1);
  localparam int LW = $clog2(LOC_TOUT + 1);

  initial begin
    if (BUS_TOUT < 2 || LOC_TOUT < 2) begin
      $error("watchdog counts too small");
    end
  end

  lbd_ack_if ai ();

  // processor clock divider: one enable per two system clocks
  logic cpu_clk_r;
  logic cpu_tick;
  assign cpu_tick = cpu_clk_r;

  // address decode
  logic [23:0] addr;
  logic in_ram;
  logic in_prom;
  logic in_io;
  logic in_boot;
  logic [23:0] ram_ofs;
  logic [23:0] prom_ofs;
  lbd_pkg::lbd_sel_t sel;
  assign addr = {CPU_ADDR, 1'b0};
  assign ram_ofs = addr - RAM_BASE;
  assign prom_ofs = addr - PROM_BASE;
  assign in_ram = (addr >= RAM_BASE) && (ram_ofs < lbd_pkg::RAM_SIZE);
  assign in_prom = (addr >= PROM_BASE) &&
                   (prom_ofs <= lbd_pkg::PROM_LAST_OFS);
  assign in_io = (addr >= lbd_pkg::IO_BASE);

  // boot redirect: count of accesses since reset
  logic [2:0] boot_cnt_r;
  logic as_d_r;
  logic as_start;
  logic as_end;
  logic acc_act;
  assign acc_act = !CPU_AS_N;
  assign as_start = acc_act && !as_d_r;
  assign as_end = !acc_act && as_d_r;
  // redirect ignores base and window, covering stack and pc fetches
  assign in_boot = (boot_cnt_r < 3'(lbd_pkg::BOOT_ACCESSES));

  // boot wins over everything, then io, prom, ram; else vme
  assign sel = in_boot ? lbd_pkg::LBD_SEL_PROM :
               in_io ? lbd_pkg::LBD_SEL_IO :
               in_prom ? lbd_pkg::LBD_SEL_PROM :
               in_ram ? lbd_pkg::LBD_SEL_RAM :
               lbd_pkg::LBD_SEL_VME;

  logic mem_acc;
  logic vme_acc;
  logic io_acc;
  assign mem_acc = acc_act && !CPU_IACK &&
                   (sel == lbd_pkg::LBD_SEL_RAM ||
                    sel == lbd_pkg::LBD_SEL_PROM);
  assign vme_acc = acc_act && !CPU_IACK && (sel == lbd_pkg::LBD_SEL_VME);
  assign io_acc = acc_act && !CPU_IACK && (sel == lbd_pkg::LBD_SEL_IO);

  // memory acknowledge generator
  assign ai.run = mem_acc;
  assign ai.tick = cpu_tick;
  assign ai.wait_cyc = (sel == lbd_pkg::LBD_SEL_RAM) ? RAM_WAIT :
                       PROM_WAIT;

  lbd_ack_gen #(.TAPS(lbd_pkg::ACK_TAPS)) u_ack (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .a(ai.gen)
  );

  // acknowledge merge; memory never waits on a device
  logic dtack;
  assign dtack = (mem_acc && ai.ack) ||
                 (vme_acc && !VME_DTACK_N) ||
                 (io_acc && !IO_DTACK_N) ||
                 (acc_act && CPU_IACK && !IO_DTACK_N);

  // watchdogs
  logic [LW-1:0] loc_cnt_r;
  logic [BW-1:0] bus_cnt_r;
  logic loc_to;
  logic bus_to;
  logic vas_d_r;
  logic vas_act;
  logic loc_watch;
  assign vas_act = !VME_AS_N;
  // memory accesses are excluded so they can never time out
  assign loc_watch = acc_act && !mem_acc && !dtack;
  assign loc_to = (loc_cnt_r == LW'(LOC_TOUT));
  assign bus_to = (bus_cnt_r == BW'(BUS_TOUT));

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      cpu_clk_r <= 1'b0;
      as_d_r <= 1'b0;
      vas_d_r <= 1'b0;
    end else begin
      cpu_clk_r <= !cpu_clk_r;
      as_d_r <= acc_act;
      vas_d_r <= vas_act;
    end
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      boot_cnt_r <= 3'h0;
    end else if (as_end && in_boot) begin
      boot_cnt_r <= boot_cnt_r + 3'h1;
    end
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      loc_cnt_r <= '0;
    end else if (as_start || !loc_watch) begin
      loc_cnt_r <= '0;
    end else if (!loc_to) begin
      loc_cnt_r <= loc_cnt_r + LW'(1);
    end
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      bus_cnt_r <= '0;
    end else if (!vas_act || (vas_act && !vas_d_r)) begin
      bus_cnt_r <= '0;
    end else if (!bus_to) begin
      bus_cnt_r <= bus_cnt_r + BW'(1);
    end
  end

  // local error and bus error from backplane both reach cpu only when enabled
  assign CPU_BERR_N = !(BERR_CPU_EN && acc_act &&
                        (loc_to || (vme_acc && !VME_BERR_IN_N)));
  // bus timeout only drives backplane when system controller
  assign VME_BERR_OUT = 1'b0;
  assign VME_BERR_OE = SYS_CTRL_EN && bus_to;

  // 16 mhz sysclk by phase accumulator, approximate duty cycle
  logic [lbd_pkg::SYSCLK_ACC_W-1:0] acc_r;
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      acc_r <= '0;
    end else begin
      acc_r <= acc_r + lbd_pkg::SYSCLK_STEP;
    end
  end
  assign VME_SYSCLK_OUT = acc_r[lbd_pkg::SYSCLK_ACC_W-1];
  assign VME_SYSCLK_OE = SYSCLK_DRIVE_EN;

  // on-board sources: selectable priority, one composite request
  logic [1:0] onb_p [3];
  logic [2:0] onb_win;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_onb
      assign onb_p[gi] = ONB_PRIO[2*gi +: 2];
    end
  endgenerate
  always_comb begin
    onb_win = 3'h0;
    for (int i = 0; i < 3; i++) begin
      if (ONB_IRQ[i] && (onb_win == 3'h0 ||
          onb_p[i] > onb_p[(onb_win == 3'h2) ? 1 :
                          (onb_win == 3'h4) ? 2 : 0])) begin
        onb_win = 3'(1 << i);
      end
    end
  end
  assign ONBOARD_COMPOSITE_IRQ = |ONB_IRQ;

  // seven-input priority encoder onto the three level bits
  logic [7:1] lvl_req;
  logic [2:0] ipl;
  generate
    for (gi = 1; gi < 8; gi++) begin : g_lvl
      assign lvl_req[gi] = (IRQ_ROUTE_EN[gi] && !VME_IRQ_N[gi]) ||
                           (ONBOARD_COMPOSITE_IRQ &&
                            ONBOARD_LEVEL == 3'(gi));
    end
  endgenerate
  always_comb begin
    ipl = 3'h0;
    for (int i = 1; i < 8; i++) begin
      if (lvl_req[i]) begin
        ipl = 3'(i);
      end
    end
  end

  // iack: one-of-eight on address lines one to three
  logic [7:0] iack_dec;
  assign iack_dec = 8'(1 << CPU_ADDR[3:1]);
  logic iack_on;
  assign iack_on = acc_act && CPU_IACK;

  // registered outputs
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      CPU_IRQ_LEVEL_BIT2 <= 1'b0;
      CPU_IRQ_LEVEL_BIT1 <= 1'b0;
      CPU_IRQ_LEVEL_BIT0 <= 1'b0;
      ONB_IACK <= 3'h0;
      IACK_AUTOVEC <= 1'b0;
      IACK_VECTORED <= 1'b0;
    end else begin
      CPU_IRQ_LEVEL_BIT2 <= ipl[2];
      CPU_IRQ_LEVEL_BIT1 <= ipl[1];
      CPU_IRQ_LEVEL_BIT0 <= ipl[0];
      IACK_AUTOVEC <= iack_on &&
                      |(iack_dec[7:1] & AUTOVEC_SEL);
      IACK_VECTORED <= iack_on &&
                       |(iack_dec[7:1] & ~AUTOVEC_SEL);
      ONB_IACK <= (iack_on && iack_dec[ONBOARD_LEVEL] &&
                   !AUTOVEC_SEL[ONBOARD_LEVEL]) ? onb_win : 3'h0;
    end
  end

  assign CPU_CLK = cpu_clk_r;
  assign CPU_DTACK_N = !dtack;
  assign VME_CYCLE = vme_acc;
  assign RAM_SEL = acc_act && sel == lbd_pkg::LBD_SEL_RAM;
  assign PROM_SEL = acc_act && sel == lbd_pkg::LBD_SEL_PROM;
  assign IO_SEL = io_acc;
  assign BOOT_ACTIVE = in_boot;

  // status glue
  assign BOARD_FAIL_LED = BOARD_FAIL_FLAG;
  assign VME_SYSFAIL_OUT = 1'b0;
  assign VME_SYSFAIL_OE = BOARD_FAIL_FLAG;
  assign SYSFAIL_STATUS_IN = !VME_SYSFAIL_IN_N;
  assign ACFAIL_STATUS_IN = !VME_ACFAIL_IN_N;
  assign SYSFAIL_HANDSHAKE_IN = !VME_SYSFAIL_IN_N;
  assign ACFAIL_HANDSHAKE_IN = !VME_ACFAIL_IN_N;
endmodule

// ===== dv/lbd_vme_slave.sv
// far-side stand-in: vme slave and on-board peripheral
`timescale 1ns/100ps
module lbd_vme_slave (
  input wire logic clk,
  input wire logic as_n,
  input wire logic vme_cyc,
  input wire logic io_sel,
  input wire logic [3:0] dly,
  input wire logic mute,
  output logic vme_as_n,
  output logic vme_dtack_n,
  output logic io_dtack_n
);
  logic [7:0] cnt_r;
  wire rdy = !as_n && !mute && cnt_r >= {4'h0, dly};
  // backplane strobe only for routed cycles
  assign vme_as_n = as_n | ~vme_cyc;
  // pulled-up lines: released means high, never the last value
  assign vme_dtack_n = !(rdy && vme_cyc);
  assign io_dtack_n = !(rdy && io_sel);
  always_ff @(posedge clk)
    cnt_r <= as_n ? 8'h00 : cnt_r + 8'h01;
endmodule

// ===== dv/lbd_asserts.sv
// concurrent checks on the decode and acknowledge top ports
`timescale 1ns/100ps
module lbd_asserts #(
  parameter int BUS_TOUT = 20,
  parameter int LOC_TOUT = 10
) (
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic CPU_AS_N,
  input wire logic CPU_IACK,
  input wire logic [3:0] RAM_WAIT,
  input wire logic [3:0] PROM_WAIT,
  input wire logic BERR_CPU_EN,
  input wire logic SYS_CTRL_EN,
  input wire logic VME_AS_N,
  input wire logic VME_DTACK_N,
  input wire logic CPU_DTACK_N,
  input wire logic CPU_BERR_N,
  input wire logic VME_CYCLE,
  input wire logic RAM_SEL,
  input wire logic PROM_SEL,
  input wire logic IO_SEL,
  input wire logic BOOT_ACTIVE,
  input wire logic VME_BERR_OE
);
  int vcnt_r;
  int lcnt_r;
  wire mem = RAM_SEL | PROM_SEL;
  // memory never times out, so it never feeds the local count
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      vcnt_r <= 0;
      lcnt_r <= 0;
    end else begin
      vcnt_r <= VME_AS_N ? 0 : vcnt_r + 1;
      lcnt_r <= (CPU_AS_N || mem || !CPU_DTACK_N) ? 0 : lcnt_r + 1;
    end
  end
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (SYS_RST);
  sequence s_ram_tap0;
    $fell(CPU_AS_N) && RAM_SEL && RAM_WAIT == 4'h0;
  endsequence
  sequence s_ack_soon;
    CPU_DTACK_N ##[1:3] !CPU_DTACK_N;
  endsequence
  a_ram_tap0: assert property (s_ram_tap0 |-> s_ack_soon)
    else $error("ram ack off tap 0");
  a_prom_tap8: assert property ($fell(CPU_AS_N) && PROM_SEL &&
    PROM_WAIT == 4'h8 |-> CPU_DTACK_N [*8] ##[10:12] !CPU_DTACK_N)
    else $error("prom ack off tap 8");
  a_ack_drop: assert property ($rose(CPU_AS_N) |-> CPU_DTACK_N)
    else $error("ack held after strobe");
  a_vme_ack: assert property (!CPU_AS_N && VME_CYCLE &&
    !VME_DTACK_N |-> !CPU_DTACK_N) else $error("slave ack lost");
  a_vme_dflt: assert property (!CPU_AS_N && !CPU_IACK &&
    !BOOT_ACTIVE && !mem && !IO_SEL |-> VME_CYCLE)
    else $error("unmapped not vme");
  a_boot_prom: assert property (!CPU_AS_N && BOOT_ACTIVE
    |-> PROM_SEL && !RAM_SEL && !VME_CYCLE) else $error("boot not prom");
  a_mem_no_berr: assert property (!CPU_AS_N && mem |-> CPU_BERR_N)
    else $error("memory bus error");
  a_loc_tout: assert property (BERR_CPU_EN &&
    lcnt_r == LOC_TOUT - 3 |-> ##[1:6] !CPU_BERR_N)
    else $error("local timeout missing");
  a_bus_early: assert property (vcnt_r > 0 &&
    vcnt_r < BUS_TOUT - 3 |-> !VME_BERR_OE) else $error("bus berr early");
  a_bus_late: assert property (SYS_CTRL_EN &&
    vcnt_r == BUS_TOUT - 3 |-> ##[1:6] VME_BERR_OE)
    else $error("bus berr missing");
endmodule
bind lbd_top lbd_asserts #(.BUS_TOUT(BUS_TOUT), .LOC_TOUT(LOC_TOUT)) u_chk (.*);

// ===== dv/lbd_tb_top.sv
// self-checking bench for the decode and acknowledge block
`timescale 1ns/100ps
module lbd_tb_top;
  localparam logic [4:0] E_VME = 5'h11, E_RAM = 5'h09;
  localparam logic [4:0] E_PROM = 5'h05, E_IO = 5'h03;
  logic CLK_SYS, SYS_RST, CPU_AS_N, CPU_IACK, IO_DTACK_N, VME_DTACK_N;
  logic VME_BERR_IN_N, VME_AS_N, BERR_CPU_EN, SYS_CTRL_EN, SYSCLK_DRIVE_EN;
  logic BOARD_FAIL_FLAG, VME_SYSFAIL_IN_N, VME_ACFAIL_IN_N, mute, got;
  logic [23:1] CPU_ADDR;
  logic [23:0] RAM_BASE, PROM_BASE;
  logic [3:0] RAM_WAIT, PROM_WAIT, dly;
  logic [7:1] VME_IRQ_N, IRQ_ROUTE_EN, AUTOVEC_SEL;
  logic [2:0] ONBOARD_LEVEL, ONB_IRQ, ONB_IACK;
  logic [5:0] ONB_PRIO;
  logic CPU_CLK, CPU_DTACK_N, CPU_BERR_N, VME_CYCLE, RAM_SEL, PROM_SEL;
  logic IO_SEL, BOOT_ACTIVE, VME_BERR_OUT, VME_BERR_OE, VME_SYSCLK_OUT;
  logic VME_SYSCLK_OE, CPU_IRQ_LEVEL_BIT2, CPU_IRQ_LEVEL_BIT1;
  logic CPU_IRQ_LEVEL_BIT0, ONBOARD_COMPOSITE_IRQ, IACK_AUTOVEC;
  logic IACK_VECTORED, BOARD_FAIL_LED, VME_SYSFAIL_OUT, VME_SYSFAIL_OE;
  logic SYSFAIL_STATUS_IN, ACFAIL_STATUS_IN, SYSFAIL_HANDSHAKE_IN;
  logic ACFAIL_HANDSHAKE_IN;
  logic [4:0] exp_q[$];
  int error_cnt = 0, n_checks = 0, cyc = 0;
  logic [23:0] ta[10] = '{24'h000000, 24'h01FFFE, 24'h020000, 24'hF7FFFE,
    24'hF80000, 24'hFAFFFE, 24'hFB0000, 24'hFEFFFE, 24'hFF0000, 24'hFFFFFE};
  logic [4:0] te[10] = '{E_RAM, E_RAM, E_VME, E_VME, E_PROM, E_PROM,
    E_VME, E_VME, E_IO, E_IO};
  // short timeouts keep the run small
  lbd_top #(.BUS_TOUT(20), .LOC_TOUT(10)) DUT (.*);
  lbd_vme_slave u_slv (.clk(CLK_SYS), .as_n(CPU_AS_N), .vme_cyc(VME_CYCLE),
    .io_sel(IO_SEL), .dly(dly), .mute(mute), .vme_as_n(VME_AS_N),
    .vme_dtack_n(VME_DTACK_N), .io_dtack_n(IO_DTACK_N));
  initial begin
    CLK_SYS = 1'b0;
    forever #5 CLK_SYS = ~CLK_SYS;
  end
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // request held until the answer is sampled at an edge
  task automatic acc(logic [23:0] a, logic [4:0] e, output int n);
    CPU_ADDR <= a[23:1];
    CPU_AS_N <= 1'b0;
    exp_q.push_back(e);
    n = 0;
    do begin
      @(posedge CLK_SYS);
      n++;
    end while (CPU_DTACK_N && CPU_BERR_N && n < 60);
    CPU_AS_N <= 1'b1;
    @(posedge CLK_SYS);
  endtask
  always @(posedge CLK_SYS) begin
    if (CPU_AS_N)
      got = 1'b0;
    else if (!got && (!CPU_DTACK_N || !CPU_BERR_N) && exp_q.size() > 0) begin
      got = 1'b1;
      chk("decode", {3'h0, VME_CYCLE, RAM_SEL, PROM_SEL, IO_SEL, CPU_BERR_N},
        {3'h0, exp_q.pop_front()});
    end
  end
  always @(posedge CLK_SYS) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      print_verdict();
    end
  end
  initial begin
    int n;
    int r;
    {SYS_RST, CPU_AS_N, VME_BERR_IN_N, BERR_CPU_EN, SYS_CTRL_EN} = 5'h1F;
    {CPU_IACK, SYSCLK_DRIVE_EN, BOARD_FAIL_FLAG, mute, got} = 5'h00;
    {VME_SYSFAIL_IN_N, VME_ACFAIL_IN_N, CPU_ADDR} = {2'h3, 23'h000000};
    {ONBOARD_LEVEL, ONB_IRQ, ONB_PRIO} = 12'h000;
    {RAM_WAIT, PROM_WAIT, dly} = 12'h021;
    {RAM_BASE, PROM_BASE} = {24'h000000, 24'hF80000};
    {VME_IRQ_N, IRQ_ROUTE_EN, AUTOVEC_SEL} = {7'h7F, 14'h0000};
    r = $urandom(78902);
    repeat (12) @(posedge CLK_SYS);
    SYS_RST <= 1'b0;
    @(posedge CLK_SYS);
    chk("boot", {7'h00, BOOT_ACTIVE}, 8'h01);
    for (int i = 0; i < 4; i++)
      acc({7'h00, 16'($urandom), 1'b0}, E_PROM, n);
    // count bumps on the edge that ends the last strobe
    @(posedge CLK_SYS);
    chk("boot", {7'h00, BOOT_ACTIVE}, 8'h00);
    for (int i = 0; i < 10; i++) begin
      dly <= 4'($urandom % 5);
      acc(ta[i], te[i], n);
    end
    for (int t = 0; t < 9; t++) begin
      {RAM_WAIT, PROM_WAIT} <= {4'(t), 4'(t)};
      for (int j = 0; j < 2; j++) begin
        acc({4'(j) * 4'hF, 3'(j) * 3'h4, 16'($urandom), 1'b0},
          j ? E_PROM : E_RAM, n);
        chk("wait", 8'(n > 2 * t && n < 2 * t + 5), 8'h01);
      end
    end
    mute <= 1'b1;
    acc(24'hFF0100, 5'h02, n);
    acc(24'h400000, 5'h10, n);
    BERR_CPU_EN <= 1'b0;
    for (int e = 0; e < 2; e++) begin
      {SYS_CTRL_EN, CPU_AS_N} <= {1'(e), 1'b0};
      repeat (26) @(posedge CLK_SYS);
      chk("bus tout", {7'h00, VME_BERR_OE}, 8'(e));
      CPU_AS_N <= 1'b1;
      repeat (2) @(posedge CLK_SYS);
      chk("bus clr", {7'h00, VME_BERR_OE}, 8'h00);
    end
    {mute, BERR_CPU_EN, IRQ_ROUTE_EN} <= {2'h1, 7'h7F};
    for (int k = 1; k < 9; k++) begin
      if (k == 8)
        {VME_IRQ_N, IRQ_ROUTE_EN, ONB_IRQ} <= {7'h00, 7'h3F, 3'h4};
      else
        VME_IRQ_N <= 7'h7F << k;
      repeat (2) @(posedge CLK_SYS);
      chk("ipl", {4'h0, ONBOARD_COMPOSITE_IRQ, CPU_IRQ_LEVEL_BIT2,
        CPU_IRQ_LEVEL_BIT1, CPU_IRQ_LEVEL_BIT0},
        k == 8 ? 8'h0E : 8'(k));
    end
    {VME_IRQ_N, ONB_IRQ, AUTOVEC_SEL} <= {10'h3F8, 7'($urandom)};
    for (int k = 1; k < 8; k++) begin
      {CPU_IACK, CPU_AS_N, CPU_ADDR} <= {2'h2, 20'hFFFFF, 3'(k)};
      repeat (3) @(posedge CLK_SYS);
      chk("iack", {6'h00, IACK_AUTOVEC, IACK_VECTORED},
        {6'h00, AUTOVEC_SEL[k], !AUTOVEC_SEL[k]});
      {CPU_IACK, CPU_AS_N} <= 2'h1;
      @(posedge CLK_SYS);
    end
    for (int i = 0; i < 8; i++) begin
      {VME_SYSFAIL_IN_N, VME_ACFAIL_IN_N, BOARD_FAIL_FLAG} <= 3'(i);
      repeat (2) @(posedge CLK_SYS);
      chk("fail", {2'h0, BOARD_FAIL_LED, VME_SYSFAIL_OE, SYSFAIL_STATUS_IN,
        SYSFAIL_HANDSHAKE_IN, ACFAIL_STATUS_IN, ACFAIL_HANDSHAKE_IN},
        {2'h0, {2{i[0]}}, {2{!i[2]}}, {2{!i[1]}}});
    end
    {SYSCLK_DRIVE_EN, n, r} <= {1'b1, 64'h0};
    repeat (256) begin
      @(posedge CLK_SYS);
      r += int'(VME_SYSCLK_OUT && !n[0]);
      n = int'(VME_SYSCLK_OUT);
    end
    chk("sysclk", {7'h00, VME_SYSCLK_OE}, 8'(r > 39 && r < 43));
    chk("pending", 8'(exp_q.size()), 8'h00);
    print_verdict();
  end
endmodule
